// file: include/usrx_cfg.svh
`ifndef USRX_CFG_SVH
`define USRX_CFG_SVH

// Register indices; byte address is four times the index.
`define USRX_IDX_FLAGS     8'h0c
`define USRX_IDX_RXSTAT    8'h18
`define USRX_IDX_RXDATA    8'h1a
`define USRX_IDX_ENABLES   8'h8c
`define USRX_IDX_TXSTAT    8'h98
`define USRX_IDX_BAUD      8'h99

// Field positions.
`define USRX_FLAG_RX_BIT   5
`define USRX_RS_SERIAL_PORT_ENABLE_BIT   7
`define USRX_RS_RX9_BIT    6
`define USRX_RS_SINGLE_RECEIVE_ENABLE_BIT   5
`define USRX_RS_CONTINUOUS_RECEIVE_ENABLE_BIT   4
`define USRX_RS_FRAMING_ERROR_BIT   2
`define USRX_RS_OVERRUN_ERROR_BIT   1
`define USRX_RS_NINTH_RX_BIT_VALUE_BIT   0
`define USRX_TS_CLOCK_SOURCE_MASTER_BIT   7
`define USRX_TS_SYNC_BIT   4
`define USRX_TS_TRANSMIT_SHIFT_EMPTY_BIT   1

// Reset values.
`define USRX_RST_FLAGS     8'h00
`define USRX_RST_RXSTAT    8'h00
`define USRX_RST_ENABLES   8'h00
`define USRX_RST_TXSTAT    8'h02
`define USRX_RST_BAUD      8'h00

// Writable masks: bit 6 of flags and enables is reserved.
`define USRX_WMASK_ENABLES 8'hbf
`define USRX_WMASK_RXSTAT  8'hf0
`define USRX_WMASK_TXSTAT  8'hfd

`endif

// file: include/usrx_pkg.sv
package usrx_pkg;

    typedef enum logic [2:0] {
        USRX_IDLE  = 3'b001,
        USRX_SHIFT = 3'b010,
        USRX_DONE  = 3'b100
    } usrx_phase_type;

    typedef struct packed {
        logic       ninth;
        logic [7:0] data;
    } usrx_word_type;

    typedef struct packed {
        logic [7:0] enables;
        logic [7:0] rxctl;
        logic [7:0] txctl;
        logic [7:0] baud;
    } usrx_regs_type;

endpackage

// file: hdl/usrx_sync_master_rx.sv
// Contract
// RL1 - Either receive enable starts synchronous reception.
// RL2 - Sample data on falling shift-clock edge.
// RL3 - Single enable receives exactly one word.
// RL4 - Continuous enable receives until cleared.
// RL5 - Continuous enable wins over single enable.
// RL6 - Completed word moves into FIFO if room.
// RL7 - Word into FIFO sets receive ready flag.
// RL8 - Interrupt only while receive irq enabled.
// RL9 - Flag read-only, clears when FIFO empty.
// RL10 - Two-entry FIFO, third word may shift.
// RL11 - Full FIFO at last bit: overrun, drop.
// RL12 - Overrun clears only by clearing continuous.
// RL13 - Overrun blocks shift-register-to-FIFO transfers.
// RL14 - Ninth bit buffered, status shows head entry.
// RL15 - Software reads status before data register.
// RL16 - Software setup order before enabling receive.
// RL17 - Software keeps reserved bit six clear.
// RL18 - Master drives shift clock at divisor rate.
// RL19 - Single enable clears after its word.
//
// Our own choice: the APB slave port.
`include "usrx_cfg.svh"
module usrx_sync_master_rx
    import usrx_pkg::*;
#(
    parameter int FIFO_DEPTH = 2
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        sync_data_line,
    output logic             sync_clock_line,
    output logic             sync_clock_line_oe
);

    typedef struct packed {
        usrx_regs_type            regs;
        usrx_phase_type           phase;
        logic [7:0]               baud_cnt;
        logic                     sck;
        logic                     oe;
        logic [3:0]               bit_cnt;
        logic [8:0]               shift;
        logic                     overrun_error;
        usrx_word_type [FIFO_DEPTH-1:0] fifo;
        logic [1:0]               count;
        logic                     rd_ptr;
        logic                     wr_ptr;
        logic                     dat_m;
        logic                     dat_s;
        logic [31:0]              prdata;
        logic                     pready;
        logic                     pslverr;
        logic                     irq;
    } usrx_state_type;

    usrx_state_type st_ff;
    usrx_state_type nxt_st;

    logic       acc;
    logic       wr;
    logic       rd;
    logic [9:0] idx;
    logic       run_en;
    logic       fall;
    logic [3:0] nbits;
    logic       pop;
    logic       push;
    logic [7:0] rs_view;
    logic [7:0] fl_view;
    logic       fifo_full;
    usrx_word_type                  rx_word;
    usrx_word_type [FIFO_DEPTH-1:0] fifo_nxt;

    assign acc = psel && penable && !st_ff.pready;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign idx = paddr[11:2];
    // Reception needs port enable, sync mode and master clock source.
    assign run_en = st_ff.regs.rxctl[`USRX_RS_SERIAL_PORT_ENABLE_BIT]
                 && st_ff.regs.txctl[`USRX_TS_SYNC_BIT]
                 && st_ff.regs.txctl[`USRX_TS_CLOCK_SOURCE_MASTER_BIT]
                 && (st_ff.regs.rxctl[`USRX_RS_SINGLE_RECEIVE_ENABLE_BIT]
                  || st_ff.regs.rxctl[`USRX_RS_CONTINUOUS_RECEIVE_ENABLE_BIT]); // RL1
    assign nbits = st_ff.regs.rxctl[`USRX_RS_RX9_BIT] ? 4'h9 : 4'h8;
    assign fall = st_ff.sck && (st_ff.baud_cnt == st_ff.regs.baud);
    assign pop = rd && (idx == {2'h0, `USRX_IDX_RXDATA})
              && (st_ff.count != 2'h0);
    assign fifo_full = (st_ff.count == 2'(FIFO_DEPTH));
    // A read in the same cycle frees an entry, so a full FIFO that is
    // being read still takes the word instead of flagging an overrun.
    assign push = (st_ff.phase == USRX_DONE) && !st_ff.overrun_error // RL13
               && (!fifo_full || pop); // RL6
    // Eight-bit words sit in the top of the shifter, nine-bit words fill it.
    assign rx_word = (nbits == 4'h9)
                   ? {st_ff.shift[8], st_ff.shift[7:0]}
                   : {1'b0, st_ff.shift[8:1]}; // RL14

    // Only the entry under the write pointer takes a finished word.
    for (genvar g = 0; g < FIFO_DEPTH; g = g + 1) begin : g_entry
        assign fifo_nxt[g] = (push && (int'(st_ff.wr_ptr) == g))
                           ? rx_word : st_ff.fifo[g]; // RL10
    end

    always_comb begin
        rs_view = st_ff.regs.rxctl & `USRX_WMASK_RXSTAT;
        rs_view[`USRX_RS_OVERRUN_ERROR_BIT] = st_ff.overrun_error;
        rs_view[`USRX_RS_FRAMING_ERROR_BIT] = 1'b0;
        rs_view[`USRX_RS_NINTH_RX_BIT_VALUE_BIT] = st_ff.fifo[st_ff.rd_ptr].ninth; // RL14
        fl_view = `USRX_RST_FLAGS;
        fl_view[`USRX_FLAG_RX_BIT] = (st_ff.count != 2'h0); // RL9
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.dat_m = sync_data_line;
        nxt_st.dat_s = st_ff.dat_m;

        // Register bus.
        nxt_st.pready = acc;
        nxt_st.pslverr = 1'b0;
        if (acc) begin
            nxt_st.prdata = 32'h0000_0000;
            case (idx)
                {2'h0, `USRX_IDX_FLAGS}: begin
                    nxt_st.prdata[7:0] = fl_view;
                end
                {2'h0, `USRX_IDX_RXSTAT}: begin
                    nxt_st.prdata[7:0] = rs_view;
                    if (wr) begin
                        nxt_st.regs.rxctl = pwdata[7:0] & `USRX_WMASK_RXSTAT;
                        if (!pwdata[`USRX_RS_CONTINUOUS_RECEIVE_ENABLE_BIT]) begin
                            nxt_st.overrun_error = 1'b0; // RL12
                        end
                    end
                end
                {2'h0, `USRX_IDX_RXDATA}: begin
                    nxt_st.prdata[7:0] = st_ff.fifo[st_ff.rd_ptr].data;
                end
                {2'h0, `USRX_IDX_ENABLES}: begin
                    nxt_st.prdata[7:0] = st_ff.regs.enables;
                    if (wr) begin
                        nxt_st.regs.enables =
                            pwdata[7:0] & `USRX_WMASK_ENABLES;
                    end
                end
                {2'h0, `USRX_IDX_TXSTAT}: begin
                    nxt_st.prdata[7:0] = st_ff.regs.txctl | 8'h02;
                    if (wr) begin
                        nxt_st.regs.txctl = pwdata[7:0] & `USRX_WMASK_TXSTAT;
                    end
                end
                {2'h0, `USRX_IDX_BAUD}: begin
                    nxt_st.prdata[7:0] = st_ff.regs.baud;
                    if (wr) begin
                        nxt_st.regs.baud = pwdata[7:0];
                    end
                end
                default: begin
                    nxt_st.pslverr = 1'b1;
                end
            endcase
        end

        // Shift clock generation and sampling.
        case (st_ff.phase)
            USRX_IDLE: begin
                nxt_st.sck = 1'b0;
                nxt_st.baud_cnt = 8'h00;
                if (run_en) begin
                    nxt_st.phase = USRX_SHIFT;
                    nxt_st.bit_cnt = 4'h0;
                end
            end
            USRX_SHIFT: begin
                if (!run_en) begin
                    nxt_st.phase = USRX_IDLE;
                    nxt_st.sck = 1'b0;
                end else if (st_ff.baud_cnt == st_ff.regs.baud) begin
                    nxt_st.baud_cnt = 8'h00;
                    nxt_st.sck = !st_ff.sck; // RL18
                    if (fall) begin
                        nxt_st.shift = {st_ff.dat_s, st_ff.shift[8:1]}; // RL2
                        nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
                        if (st_ff.bit_cnt + 4'h1 == nbits) begin
                            nxt_st.phase = USRX_DONE;
                        end
                    end
                end else begin
                    nxt_st.baud_cnt = st_ff.baud_cnt + 8'h01;
                end
            end
            USRX_DONE: begin
                if (!st_ff.overrun_error && fifo_full && !pop) begin
                    nxt_st.overrun_error = 1'b1; // RL11
                end
                nxt_st.bit_cnt = 4'h0;
                nxt_st.baud_cnt = 8'h00;
                if (st_ff.regs.rxctl[`USRX_RS_CONTINUOUS_RECEIVE_ENABLE_BIT]) begin
                    nxt_st.phase = USRX_SHIFT; // RL4 RL5
                end else begin
                    nxt_st.regs.rxctl[`USRX_RS_SINGLE_RECEIVE_ENABLE_BIT] = 1'b0; // RL3 RL19
                    nxt_st.phase = USRX_IDLE;
                end
            end
            default: begin
                nxt_st.phase = USRX_IDLE;
            end
        endcase

        // FIFO bookkeeping.
        nxt_st.fifo = fifo_nxt;
        if (push) begin
            nxt_st.wr_ptr = !st_ff.wr_ptr; // RL10
        end
        if (pop) begin
            nxt_st.rd_ptr = !st_ff.rd_ptr; // RL10
        end
        nxt_st.count = st_ff.count + {1'b0, push} - {1'b0, pop}; // RL7 RL9

        nxt_st.irq = (nxt_st.count != 2'h0)
                  && nxt_st.regs.enables[`USRX_FLAG_RX_BIT]; // RL8
        // The clock enable is registered with the phase so the pin driver
        // sees no decode glitch when the engine changes state.
        nxt_st.oe = (nxt_st.phase != USRX_IDLE); // RL18
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
            st_ff.regs.txctl <= `USRX_RST_TXSTAT;
            st_ff.phase <= USRX_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign irq = st_ff.irq;
    assign sync_clock_line = st_ff.sck;
    assign sync_clock_line_oe = st_ff.oe;

endmodule

// file: bench/usrx_slave_model.sv
module usrx_slave_model (
    input  wire logic sck,
    input  wire logic oe,
    input  wire logic nine,
    output logic      dout,
    output int        nw
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] idx = 4'h0;
    logic [3:0] last;
    logic [8:0] w;
    assign last = nine ? 4'h8 : 4'h7;
    assign w = {nw[0], 8'h3c + 8'(nw * 17)};
    initial dout = 1'b1;
    initial nw = 0;
    // Bits change on the rise so they are settled at the sampling fall.
    always @(posedge sck) dout <= w[idx];
    // Only falls while the master drives the clock count as bits, so the
    // settling of the line at reset cannot skew the bit index.
    always @(negedge sck) if (oe) begin
        idx <= (idx == last) ? 4'h0 : idx + 4'h1;
        if (idx == last) nw <= nw + 1;
    end
    // A released line shows the inverse of its last level.
    always @(negedge oe) begin
        dout <= ~dout;
        idx <= 4'h0;
    end
endmodule

// file: bench/usrx_sync_master_rx_monitor.sv
module usrx_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic        sync_clock_line,
    input wire logic        sync_clock_line_oe
);
    logic       sck_ff, ien_ff, go_ff, wr;
    logic [8:0] hc_ff;
    logic [7:0] baud_ff;
    // Registers take a write at the access edge, one cycle before pready.
    assign wr = psel && penable && !pready && pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_ff <= 1'b0;
            hc_ff <= 9'h0;
            baud_ff <= 8'h0;
            ien_ff <= 1'b0;
            go_ff <= 1'b0;
        end else begin
            sck_ff <= sync_clock_line;
            hc_ff <= (sync_clock_line != sck_ff) ? 9'h0 : hc_ff + 9'h1;
            if (wr && paddr == 12'h264) baud_ff <= pwdata[7:0];
            if (wr && paddr == 12'h230) ien_ff <= pwdata[5];
            if (wr && paddr == 12'h060)
                go_ff <= pwdata[7] && (pwdata[5] || pwdata[4]);
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_wait; psel && penable && !pready; endsequence
    sequence s_start; $rose(sync_clock_line_oe); endsequence
    property p_ready; s_wait |=> pready; endproperty
    property p_pulse; pready |=> !pready; endproperty
    property p_err; pslverr |-> pready; endproperty
    // An aborted word drops the clock early, together with its enable.
    property p_half;
        $fell(sync_clock_line) && sync_clock_line_oe
            |-> hc_ff == {1'b0, baud_ff};
    endproperty
    property p_clk_oe; sync_clock_line |-> sync_clock_line_oe; endproperty
    property p_start_low; s_start |-> !sync_clock_line; endproperty
    property p_start; s_start |-> go_ff; endproperty
    property p_irq; irq |-> ien_ff || $past(ien_ff); endproperty
    a_ready: assert property (p_ready) else $error("pready late");
    a_pulse: assert property (p_pulse) else $error("pready too long");
    a_err: assert property (p_err) else $error("pslverr without pready");
    a_half: assert property (p_half) else $error("bad half period");
    a_clk_oe: assert property (p_clk_oe) else $error("clock undriven");
    a_start_low: assert property (p_start_low) else $error("bad idle");
    a_start: assert property (p_start) else $error("start unasked");
    a_irq: assert property (p_irq) else $error("irq while masked");
endmodule
bind usrx_sync_master_rx usrx_monitor i_usrx_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .sync_clock_line(sync_clock_line),
    .sync_clock_line_oe(sync_clock_line_oe));

// file: bench/usrx_sync_master_rx_bench.sv
module usrx_sync_master_rx_bench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [11:0] a; logic [31:0] d; logic e;} usrx_row_type;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, nine = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, irq, dline, sck, sck_oe;
    int          nw, errors = 0, n_tests = 0;
    usrx_row_type rows [7] = '{'{12'h030, 0, 0}, '{12'h060, 0, 0},
        '{12'h068, 0, 0}, '{12'h230, 0, 0}, '{12'h260, 2, 0},
        '{12'h264, 0, 0}, '{12'h004, 0, 1}};
    usrx_sync_master_rx i_usrx_sync_master_rx (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq),
        .sync_data_line(dline), .sync_clock_line(sck),
        .sync_clock_line_oe(sck_oe));
    usrx_slave_model i_usrx_slave_model (
        .sck(sck), .oe(sck_oe), .nine(nine), .dout(dline), .nw(nw));
    initial forever #5 pclk = ~pclk;
    function automatic logic [7:0] wd(int n);
        return 8'h3c + 8'(n * 17);
    endfunction
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [7:0] d,
                       output logic [31:0] r, output logic e);
        int k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++k < 20);
        if (k >= 20) errors++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(logic [11:0] a, logic [7:0] m, logic [7:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 8'h0, r, e);
        chk(r & {24'hffffff, m}, {24'h0, x});
    endtask
    task automatic wr(logic [11:0] a, logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic wait_nw(int n);
        int k = 0;
        while (nw < n && k++ < 4000) @(posedge pclk);
        chk(32'(nw), 32'(n));
        repeat (6) @(posedge pclk);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge pclk);
        errors++;
        report_and_stop;
    end
    initial begin
        logic [31:0] r;
        logic e;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b0, rows[i].a, 8'h0, r, e);
            chk(r, rows[i].d);
            chk({31'h0, e}, {31'h0, rows[i].e});
        end
        $display("test reset values done");
        wr(12'h264, 8'h03);
        wr(12'h260, 8'h90);
        wr(12'h230, 8'h20);
        wr(12'h060, 8'h80);
        wr(12'h060, 8'ha0);
        for (int k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        rd(12'h030, 8'h20, 8'h20);
        rd(12'h060, 8'h20, 8'h00);
        rd(12'h068, 8'hff, wd(0));
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        repeat (300) @(posedge pclk);
        chk(32'(nw), 32'h1);
        $display("test single word done");
        nine <= 1'b1;
        wr(12'h060, 8'hf0);
        wait_nw(4);
        rd(12'h060, 8'h03, 8'h03);
        wr(12'h230, 8'h00);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        wr(12'h230, 8'h20);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        rd(12'h068, 8'hff, wd(1));
        rd(12'h060, 8'h03, 8'h02);
        rd(12'h068, 8'hff, wd(2));
        wait_nw(6);
        rd(12'h030, 8'h20, 8'h00);
        wr(12'h060, 8'hc0);
        rd(12'h060, 8'h12, 8'h00);
        $display("test continuous overrun done");
        report_and_stop;
    end
endmodule
